//--- common/clkctl_map.svh
// Register map, field layout and reset values of the clock control block
`ifndef CLKCTL_MAP_SVH
`define CLKCTL_MAP_SVH
`define CLKCTL_A_HF_START 12'h000
`define CLKCTL_A_HF_STOP 12'h004
`define CLKCTL_A_LF_START 12'h008
`define CLKCTL_A_LF_STOP 12'h00C
`define CLKCTL_A_CAL 12'h010
`define CLKCTL_A_CT_START 12'h014
`define CLKCTL_A_CT_STOP 12'h018
`define CLKCTL_A_EV_HF 12'h100
`define CLKCTL_A_EV_LF 12'h104
`define CLKCTL_A_EV_DONE 12'h10C
`define CLKCTL_A_EV_CAL_TIMER_TIMEOUT_EVENT 12'h110
`define CLKCTL_A_INTEN 12'h300
`define CLKCTL_A_INTERRUPT_ENABLE_SET 12'h304
`define CLKCTL_A_INTERRUPT_ENABLE_CLEAR 12'h308
`define CLKCTL_A_HF_RUN 12'h408
`define CLKCTL_A_HF_STAT 12'h40C
`define CLKCTL_A_LF_RUN 12'h414
`define CLKCTL_A_LF_STAT 12'h418
`define CLKCTL_A_LF_SNAP 12'h41C
`define CLKCTL_A_LF_SRC 12'h518
`define CLKCTL_A_CAL_TIMER_INTERVAL 12'h538
`define CLKCTL_EV_HF 0
`define CLKCTL_EV_LF 1
`define CLKCTL_EV_DONE 2
`define CLKCTL_EV_CAL_TIMER_TIMEOUT_EVENT 3
`define CLKCTL_NEV 4
`define CLKCTL_SRC_W 2
`define CLKCTL_SRC_RC 2'h0
`define CLKCTL_SRC_XTAL 2'h1
`define CLKCTL_STAT_RUN_BIT 16
`define CLKCTL_CAL_TIMER_INTERVAL_W 7
`define CLKCTL_CAL_TIMER_INTERVAL_RST 7'h00
`define CLKCTL_ZERO32 32'h00000000
`endif

//--- common/clkctl_pkg.sv
// Types of the clock control block
package clkctl_pkg;
  typedef enum logic [1:0] {
    LF_OFF,
    LF_FROM_RC,
    LF_RUNNING
  } clkctl_lf_state_t;
endpackage

//--- hw/clkctl_cal_timer.sv
// Calibration interval timer, ticking on low-frequency clock pulses
`timescale 1ns/1ps
`include "clkctl_map.svh"
module clkctl_cal_timer #(
  parameter int CAL_TIMER_INTERVAL_W = `CLKCTL_CAL_TIMER_INTERVAL_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic stop,
  input wire logic tick,
  input wire logic [CAL_TIMER_INTERVAL_W-1:0] interval,
  output logic running,
  output logic timeout
);
  initial begin
    // One-bit counter would need a zero-width replication
    if (CAL_TIMER_INTERVAL_W < 2 || CAL_TIMER_INTERVAL_W > 16) $error("clkctl_cal_timer: CAL_TIMER_INTERVAL_W out of range");
  end
  logic [CAL_TIMER_INTERVAL_W-1:0] count_q;
  logic running_q;
  logic timeout_q;
  wire at_zero = (count_q == '0);
  // Zero interval times out on the first tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      running_q <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= 1'b0;
      if (start) begin
        count_q <= interval;
        running_q <= 1'b1;
      end else if (stop) begin
        running_q <= 1'b0;
      end else if (running_q && tick) begin
        if (at_zero || count_q == {{(CAL_TIMER_INTERVAL_W-1){1'b0}}, 1'b1}) begin
          running_q <= 1'b0;
          timeout_q <= 1'b1;
          count_q <= '0;
        end else begin
          count_q <= count_q - {{(CAL_TIMER_INTERVAL_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
  assign running = running_q;
  assign timeout = timeout_q;
endmodule

//--- hw/clkctl_regs.sv
// APB register file and control of the clock control block
`timescale 1ns/1ps
`include "clkctl_map.svh"
module clkctl_regs #(
  parameter int CAL_TIMER_INTERVAL_W = `CLKCTL_CAL_TIMER_INTERVAL_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hf_xtal_ready,
  input wire logic lf_xtal_ready,
  input wire logic lf_tick,
  input wire logic cal_finished,
  output logic hf_xtal_enable,
  output logic lf_clock_enable,
  output logic lf_use_xtal,
  output logic [1:0] lf_source,
  output logic cal_start,
  output logic irq
);
  initial begin
    if (CAL_TIMER_INTERVAL_W < 2 || CAL_TIMER_INTERVAL_W > 16) $error("clkctl_regs: CAL_TIMER_INTERVAL_W out of range");
  end

  // ********************************
  // Bus decode
  // ********************************
  wire wr = psel && penable && pwrite;
  wire wr1 = wr && pwdata[0];
  wire a_hf_start = (paddr == `CLKCTL_A_HF_START);
  wire a_hf_stop = (paddr == `CLKCTL_A_HF_STOP);
  wire a_lf_start = (paddr == `CLKCTL_A_LF_START);
  wire a_lf_stop = (paddr == `CLKCTL_A_LF_STOP);
  wire a_cal = (paddr == `CLKCTL_A_CAL);
  wire a_ct_start = (paddr == `CLKCTL_A_CT_START);
  wire a_ct_stop = (paddr == `CLKCTL_A_CT_STOP);
  wire a_ev_hf = (paddr == `CLKCTL_A_EV_HF);
  wire a_ev_lf = (paddr == `CLKCTL_A_EV_LF);
  wire a_ev_done = (paddr == `CLKCTL_A_EV_DONE);
  wire a_ev_cal_timer_timeout_event = (paddr == `CLKCTL_A_EV_CAL_TIMER_TIMEOUT_EVENT);
  wire a_inten = (paddr == `CLKCTL_A_INTEN);
  wire a_interrupt_enable_set = (paddr == `CLKCTL_A_INTERRUPT_ENABLE_SET);
  wire a_interrupt_enable_clear = (paddr == `CLKCTL_A_INTERRUPT_ENABLE_CLEAR);
  wire a_hf_run = (paddr == `CLKCTL_A_HF_RUN);
  wire a_hf_stat = (paddr == `CLKCTL_A_HF_STAT);
  wire a_lf_run = (paddr == `CLKCTL_A_LF_RUN);
  wire a_lf_stat = (paddr == `CLKCTL_A_LF_STAT);
  wire a_lf_snap = (paddr == `CLKCTL_A_LF_SNAP);
  wire a_lf_src = (paddr == `CLKCTL_A_LF_SRC);
  wire a_cal_timer_interval = (paddr == `CLKCTL_A_CAL_TIMER_INTERVAL);
  wire mapped = a_hf_start | a_hf_stop | a_lf_start | a_lf_stop | a_cal | a_ct_start | a_ct_stop
    | a_ev_hf | a_ev_lf | a_ev_done | a_ev_cal_timer_timeout_event | a_inten | a_interrupt_enable_set | a_interrupt_enable_clear
    | a_hf_run | a_hf_stat | a_lf_run | a_lf_stat | a_lf_snap | a_lf_src | a_cal_timer_interval;

  // ********************************
  // Task pulses
  // ********************************
  // Bit 0 only; a write of zero triggers nothing
  wire t_hf_start = wr1 && a_hf_start;
  wire t_hf_stop = wr1 && a_hf_stop;
  wire t_lf_start = wr1 && a_lf_start;
  wire t_lf_stop = wr1 && a_lf_stop;
  wire t_cal = wr1 && a_cal;
  wire t_ct_start = wr1 && a_ct_start;
  wire t_ct_stop = wr1 && a_ct_stop;

  // ********************************
  // Control state
  // ********************************
  logic hf_req_q;
  logic lf_req_q;
  logic [1:0] src_q;
  logic [1:0] snap_q;
  logic [CAL_TIMER_INTERVAL_W-1:0] cal_timer_interval_q;
  logic [`CLKCTL_NEV-1:0] ev_q;
  logic [`CLKCTL_NEV-1:0] inten_q;
  logic cal_q;
  logic cal_busy_q;
  clkctl_pkg::clkctl_lf_state_t lf_q;
  clkctl_pkg::clkctl_lf_state_t lf_d;
  logic ct_running;
  logic ct_timeout;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_req_q <= 1'b0;
      lf_req_q <= 1'b0;
    end else begin
      hf_req_q <= t_hf_start | (hf_req_q & ~t_hf_stop);
      lf_req_q <= t_lf_start | (lf_req_q & ~t_lf_stop);
    end
  end

  // Selection write while running is a software fault and is taken as is
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= `CLKCTL_SRC_RC;
      snap_q <= `CLKCTL_SRC_RC;
      cal_timer_interval_q <= `CLKCTL_CAL_TIMER_INTERVAL_RST;
    end else begin
      if (wr && a_lf_src) src_q <= pwdata[1:0];
      if (t_lf_start) snap_q <= src_q;
      if (wr && a_cal_timer_interval) cal_timer_interval_q <= pwdata[CAL_TIMER_INTERVAL_W-1:0];
    end
  end

  // ********************************
  // Low-frequency start sequence
  // ********************************
  wire lf_started_ev = (lf_q != clkctl_pkg::LF_RUNNING) && (lf_d == clkctl_pkg::LF_RUNNING);
  always_comb begin
    lf_d = lf_q;
    case (lf_q)
      clkctl_pkg::LF_OFF: begin
        if (t_lf_start) begin
          lf_d = (src_q == `CLKCTL_SRC_XTAL) ? clkctl_pkg::LF_FROM_RC : clkctl_pkg::LF_RUNNING;
        end
      end
      clkctl_pkg::LF_FROM_RC: begin
        if (t_lf_stop) lf_d = clkctl_pkg::LF_OFF;
        else if (lf_xtal_ready) lf_d = clkctl_pkg::LF_RUNNING;
      end
      clkctl_pkg::LF_RUNNING: begin
        if (t_lf_stop) lf_d = clkctl_pkg::LF_OFF;
      end
      default: lf_d = clkctl_pkg::LF_OFF;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lf_q <= clkctl_pkg::LF_OFF;
    else lf_q <= lf_d;
  end

  // ********************************
  // High-frequency started edge
  // ********************************
  logic hf_seen_q;
  wire hf_started_ev = hf_req_q && hf_xtal_ready && !hf_seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hf_seen_q <= 1'b0;
    else hf_seen_q <= hf_req_q && hf_xtal_ready;
  end

  // ********************************
  // Calibration
  // ********************************
  wire cal_done_ev = cal_busy_q && cal_finished;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_q <= 1'b0;
      cal_busy_q <= 1'b0;
    end else begin
      cal_q <= t_cal;
      cal_busy_q <= t_cal | (cal_busy_q & ~cal_finished);
    end
  end

  clkctl_cal_timer #(
    .CAL_TIMER_INTERVAL_W(CAL_TIMER_INTERVAL_W)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(t_ct_start),
    .stop(t_ct_stop),
    .tick(lf_tick),
    .interval(cal_timer_interval_q),
    .running(ct_running),
    .timeout(ct_timeout)
  );

  // ********************************
  // Events and interrupt
  // ********************************
  wire [`CLKCTL_NEV-1:0] ev_set = {ct_timeout, cal_done_ev, lf_started_ev, hf_started_ev};
  wire [`CLKCTL_NEV-1:0] ev_wr = {a_ev_cal_timer_timeout_event, a_ev_done, a_ev_lf, a_ev_hf} & {`CLKCTL_NEV{wr}};
  genvar gi;
  generate
    for (gi = 0; gi < `CLKCTL_NEV; gi = gi + 1) begin : g_ev
      // Set beats a clearing write in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ev_q[gi] <= 1'b0;
        else if (ev_set[gi]) ev_q[gi] <= 1'b1;
        else if (ev_wr[gi]) ev_q[gi] <= pwdata[0];
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) inten_q[gi] <= 1'b0;
        else if (wr && a_inten) inten_q[gi] <= pwdata[gi];
        else if (wr && a_interrupt_enable_set && pwdata[gi]) inten_q[gi] <= 1'b1;
        else if (wr && a_interrupt_enable_clear && pwdata[gi]) inten_q[gi] <= 1'b0;
      end
    end
  endgenerate
  assign irq = |(ev_q & inten_q);

  // ********************************
  // Read mux
  // ********************************
  wire lf_on = (lf_q != clkctl_pkg::LF_OFF);
  wire lf_is_xtal = (lf_q == clkctl_pkg::LF_RUNNING) && (snap_q == `CLKCTL_SRC_XTAL);
  wire hf_on = hf_req_q && hf_xtal_ready;
  wire [31:0] lf_stat = {15'h0, lf_on, 14'h0, lf_is_xtal ? `CLKCTL_SRC_XTAL : `CLKCTL_SRC_RC};
  wire [31:0] hf_stat = {15'h0, hf_on, 15'h0, hf_on};
  wire [31:0] rd_val =
    a_ev_hf ? {31'h0, ev_q[`CLKCTL_EV_HF]} :
    a_ev_lf ? {31'h0, ev_q[`CLKCTL_EV_LF]} :
    a_ev_done ? {31'h0, ev_q[`CLKCTL_EV_DONE]} :
    a_ev_cal_timer_timeout_event ? {31'h0, ev_q[`CLKCTL_EV_CAL_TIMER_TIMEOUT_EVENT]} :
    (a_inten | a_interrupt_enable_set | a_interrupt_enable_clear) ? {28'h0, inten_q} :
    a_hf_run ? {31'h0, hf_req_q} :
    a_hf_stat ? hf_stat :
    a_lf_run ? {31'h0, lf_req_q} :
    a_lf_stat ? lf_stat :
    a_lf_snap ? {30'h0, snap_q} :
    a_lf_src ? {30'h0, src_q} :
    a_cal_timer_interval ? {{(32-CAL_TIMER_INTERVAL_W){1'b0}}, cal_timer_interval_q} :
    `CLKCTL_ZERO32;

  logic [31:0] prdata_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= `CLKCTL_ZERO32;
    else if (psel && !penable && !pwrite) prdata_q <= rd_val;
  end
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ********************************
  // Oscillator controls
  // ********************************
  assign hf_xtal_enable = hf_req_q;
  assign lf_clock_enable = lf_on;
  assign lf_use_xtal = (lf_q == clkctl_pkg::LF_RUNNING) && (snap_q == `CLKCTL_SRC_XTAL);
  assign lf_source = snap_q;
  assign cal_start = cal_q;
  wire unused_ok = ct_running;
endmodule

//--- sim/clkctl_checker.sv
// Assertion checker for the clock control register block
`timescale 1ns/1ps
module clkctl_checker #(
  parameter int CAL_TIMER_INTERVAL_W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hf_xtal_ready,
  input wire logic lf_xtal_ready,
  input wire logic lf_tick,
  input wire logic cal_finished,
  input wire logic hf_xtal_enable,
  input wire logic lf_clock_enable,
  input wire logic lf_use_xtal,
  input wire logic [1:0] lf_source,
  input wire logic cal_start,
  input wire logic irq
);
  // ************
  // Properties
  // ************
  logic wr;
  assign wr = psel && penable && pwrite && pready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_task(logic [11:0] a);
    wr && pwdata[0] && paddr == a;
  endsequence
  a_hf_start_on: assert property (s_task(12'h000) |=> hf_xtal_enable)
    else $error("hf enable missing");
  a_hf_stop_off: assert property (s_task(12'h004) |=> !hf_xtal_enable)
    else $error("hf enable stuck");
  a_lf_start_on: assert property (s_task(12'h008) |=> lf_clock_enable)
    else $error("lf enable missing");
  a_lf_stop_off: assert property (s_task(12'h00C) |=> !lf_clock_enable)
    else $error("lf enable stuck");
  a_cal_one_pulse: assert property (s_task(12'h010) |=> cal_start ##1 !cal_start)
    else $error("cal pulse wrong");
  a_cal_has_cause: assert property (cal_start |-> $past(wr && pwdata[0] && paddr == 12'h010))
    else $error("cal pulse without write");
  a_zero_ignored: assert property (wr && !pwdata[0] && paddr == 12'h000 && !hf_xtal_enable
    |=> !hf_xtal_enable) else $error("zero write acted");
  a_xtal_switch: assert property ($rose(lf_use_xtal) |-> $past(lf_xtal_ready) && lf_clock_enable)
    else $error("switch before crystal ready");
endmodule
bind clkctl_regs clkctl_checker #(.CAL_TIMER_INTERVAL_W(CAL_TIMER_INTERVAL_W)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .hf_xtal_ready(hf_xtal_ready), .lf_xtal_ready(lf_xtal_ready), .lf_tick(lf_tick),
  .cal_finished(cal_finished), .hf_xtal_enable(hf_xtal_enable), .lf_clock_enable(lf_clock_enable),
  .lf_use_xtal(lf_use_xtal), .lf_source(lf_source), .cal_start(cal_start), .irq(irq));

//--- sim/testbench.sv
// Self-checking bench of the clock control register block
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h8803F061;
  logic pready, pslverr, err, hf_xtal_ready = 1'b0, lf_xtal_ready = 1'b0, lf_tick = 1'b0, cal_finished = 1'b0;
  logic hf_xtal_enable, lf_clock_enable, lf_use_xtal, cal_start, irq;
  logic [1:0] lf_source;
  logic [2:0] tick_cnt = 3'h0;
  int n_errors = 0, comparisons = 0, cyc = 0, k, n;
  always #10 pclk = ~pclk;
  clkctl_regs #(.CAL_TIMER_INTERVAL_W(7)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hf_xtal_ready(hf_xtal_ready), .lf_xtal_ready(lf_xtal_ready), .lf_tick(lf_tick),
    .cal_finished(cal_finished), .hf_xtal_enable(hf_xtal_enable), .lf_clock_enable(lf_clock_enable),
    .lf_use_xtal(lf_use_xtal), .lf_source(lf_source), .cal_start(cal_start), .irq(irq));
  // ************
  // Support
  // ************
  // Short low-freq period keeps timer runs brief
  always @(posedge pclk) begin
    tick_cnt <= tick_cnt + 3'h1;
    lf_tick <= (tick_cnt == 3'h7);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test;
    end
  end
  task stop_test;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
    end
  endtask
  function logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function logic [31:0] bit_of(input int b);
    return 32'h1 << b;
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wt;
    do @(posedge pclk); while (lf_tick !== 1'b1);
    @(posedge pclk);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 7; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0);
      chk("task word", rd, 32'h0);
    end
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped", err, 32'h1);
    $display("test reset done");
    lfsr = nxt(lfsr);
    apb(1'b1, 12'h304, bit_of(0));
    apb(1'b1, 12'h000, lfsr | 32'h1);
    chk("hf on", hf_xtal_enable, 32'h1);
    apb(1'b0, 12'h408, 32'h0);
    chk("hf run", rd & 32'h1, 32'h1);
    hf_xtal_ready <= 1'b1;
    for (k = 0; k < 9 && irq !== 1'b1; k++) @(posedge pclk);
    chk("irq on", irq, 32'h1);
    apb(1'b1, 12'h308, bit_of(0));
    chk("irq masked", irq, 32'h0);
    apb(1'b1, 12'h304, bit_of(0));
    apb(1'b1, 12'h100, 32'h0);
    chk("irq cleared", irq, 32'h0);
    apb(1'b1, 12'h004, 32'h1);
    chk("hf off", hf_xtal_enable, 32'h0);
    apb(1'b1, 12'h000, lfsr & 32'hFFFFFFFE);
    chk("zero write", hf_xtal_enable, 32'h0);
    $display("test hf done");
    apb(1'b1, 12'h518, 32'h1);
    apb(1'b1, 12'h008, lfsr | 32'h1);
    chk("lf on", lf_clock_enable, 32'h1);
    chk("lf src", lf_source, 32'h1);
    chk("lf on rc", lf_use_xtal, 32'h0);
    apb(1'b0, 12'h41C, 32'h0);
    chk("snapshot", rd & 32'h3, 32'h1);
    apb(1'b0, 12'h414, 32'h0);
    chk("lf run", rd & 32'h1, 32'h1);
    lf_xtal_ready <= 1'b1;
    for (k = 0; k < 20 && lf_use_xtal !== 1'b1; k++) @(posedge pclk);
    chk("lf xtal", lf_use_xtal, 32'h1);
    apb(1'b0, 12'h104, 32'h0);
    chk("lf event", rd, 32'h1);
    apb(1'b1, 12'h00C, 32'h1);
    chk("lf off", lf_clock_enable, 32'h0);
    apb(1'b1, 12'h104, 32'h0);
    apb(1'b1, 12'h518, 32'h0);
    apb(1'b1, 12'h008, lfsr | 32'h1);
    chk("lf rc on", lf_clock_enable, 32'h1);
    chk("lf rc src", lf_source, 32'h0);
    chk("lf rc only", lf_use_xtal, 32'h0);
    apb(1'b0, 12'h418, 32'h0);
    chk("lf rc stat", rd, 32'h00010000);
    apb(1'b0, 12'h104, 32'h0);
    chk("lf rc event", rd, 32'h1);
    apb(1'b1, 12'h00C, 32'h1);
    chk("lf rc off", lf_clock_enable, 32'h0);
    $display("test lf done");
    wt;
    apb(1'b1, 12'h010, lfsr | 32'h1);
    chk("cal pulse", cal_start, 32'h1);
    cal_finished <= 1'b1;
    @(posedge pclk);
    cal_finished <= 1'b0;
    apb(1'b0, 12'h10C, 32'h0);
    chk("cal done", rd, 32'h1);
    lfsr = nxt(lfsr);
    n = 2 + lfsr % 5;
    apb(1'b1, 12'h538, 32'(n));
    wt;
    apb(1'b1, 12'h014, lfsr | 32'h1);
    for (k = 1; k < 12; k++) begin
      wt;
      apb(1'b0, 12'h110, 32'h0);
      if (rd !== 32'h0) break;
    end
    chk("timeout ticks", 32'(k), 32'(n));
    apb(1'b1, 12'h110, 32'h0);
    repeat (n + 2) wt;
    apb(1'b0, 12'h110, 32'h0);
    chk("timer halted", rd, 32'h0);
    wt;
    apb(1'b1, 12'h014, 32'h1);
    wt;
    apb(1'b1, 12'h018, 32'h1);
    repeat (n + 2) wt;
    apb(1'b0, 12'h110, 32'h0);
    chk("timer stopped", rd, 32'h0);
    $display("test timer done");
    stop_test;
  end
endmodule
